// ### hdl/cmf_top.v
// Comparator output majority filter with per-channel analog controls
`timescale 1ns/1ps
`include "cmf_regs.vh"
module cmf_top
(
   // Clock and reset
   sys_clk,
   sys_rst,
   // Comparator sample clock from the clock generator, as a level
   comparator_sample_clock,
   // Raw comparator outputs, asynchronous
   comp_raw,
   // Per-channel comparator_channel_control fields
   filter_length,
   single_shot,
   start,
   hysteresis_on,
   hysteresis_level,
   speed,
   // Results
   filt_out,
   filt_valid,
   comp_done,
   // Analog front end controls
   afe_hysteresis_level_en,
   afe_hysteresis_level_level,
   afe_bias_sel
);
   // Clock and reset
   input  wire       sys_clk;
   input  wire       sys_rst;
   // Asynchronous inputs, synchronised below
   input  wire       comparator_sample_clock;
   input  wire [1:0] comp_raw;
   // Per-channel configuration, channel 0 in the low bits
   input  wire [3:0] filter_length;
   input  wire [1:0] single_shot;
   input  wire [1:0] start;
   input  wire [1:0] hysteresis_on;
   input  wire [3:0] hysteresis_level;
   input  wire [3:0] speed;
   // Filtered results
   output wire [1:0] filt_out;
   output wire [1:0] filt_valid;
   output wire [1:0] comp_done;
   // Analog front end controls
   output wire [1:0] afe_hysteresis_level_en;
   output wire [3:0] afe_hysteresis_level_level;
   output wire [3:0] afe_bias_sel;

   ////////////////////////////////////////////////////////////////////
   // Declarations

   // Sample clock synchroniser; the level comes from another domain
   reg        smp_s1_reg;      // First stage, may go metastable
   reg        smp_s2_reg;      // Second stage
   reg        smp_s3_reg;      // Third stage, checked against second
   reg        smp_lvl_reg;     // Settled sample clock level
   reg        smp_lvl_next;    // Next settled level
   reg        smp_prev_reg;    // Settled level one cycle earlier
   wire       sample_tick;     // One cycle per sample clock period

   // Raw comparator synchroniser, one bit per channel
   reg  [1:0] raw_s1_reg;      // First stage, may go metastable
   reg  [1:0] raw_s2_reg;      // Second stage
   reg  [1:0] raw_s3_reg;      // Third stage, checked against second
   reg  [1:0] raw_lvl_reg;     // Settled comparator levels
   reg  [1:0] raw_lvl_next;    // Next settled levels

   // Front end controls, registered so the analog side sees no glitch
   reg  [1:0] hysteresis_level_en_reg;     // Hysteresis enable per channel
   reg  [1:0] hysteresis_level_en_next;    // Next hysteresis enable
   reg  [3:0] hysteresis_level_level_reg;  // Hysteresis level, two bits a channel
   reg  [3:0] hysteresis_level_level_next; // Next hysteresis level
   reg  [3:0] bias_sel_reg;    // Bias select, two bits a channel

   ////////////////////////////////////////////////////////////////////
   // Helper functions

   // Settled level of a three-stage synchroniser. A change counts only
   // once the second and third stages agree, so a value caught while
   // the first stage was resolving cannot leak through as a glitch.
   function agree_level;
      input prev;   // Level settled so far
      input s2;     // Second stage
      input s3;     // Third stage
      begin
         if (s2 == s3)
            agree_level = s3;   // Both agree: take the new level
         else
            agree_level = prev; // Still moving: keep the old one
      end
   endfunction

   // Hysteresis is allowed only in continuous mode
   function hysteresis_level_allowed;
      input on;     // Channel hysteresis_on bit
      input single; // Channel single-shot select
      begin
         hysteresis_level_allowed = on & ~single;
      end
   endfunction

   // Level forwarded to the comparator; zero only while hysteresis_on is clear, single shot or not
   function [`CMF_HYSTERESIS_LEVEL_W-1:0] hysteresis_level_level_for;
      input                   on;    // Channel hysteresis_on bit
      input [`CMF_HYSTERESIS_LEVEL_W-1:0] level; // Programmed hysteresis_level
      begin
         if (on)
            hysteresis_level_level_for = level;
         else
            hysteresis_level_level_for = `CMF_HYSTERESIS_LEVEL_LVL_OFF; // Nothing to forward
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Sample clock synchroniser and tick

   // Each phase of the sample clock must last two system cycles or
   // more; a shorter phase never settles and that sample is lost
   always @*
   begin
      smp_lvl_next = agree_level(smp_lvl_reg, smp_s2_reg, smp_s3_reg);
   end

   // Three flip-flops on the asynchronous sample clock level
   always @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         smp_s1_reg   <= `CMF_SMP_RST;
         smp_s2_reg   <= `CMF_SMP_RST;
         smp_s3_reg   <= `CMF_SMP_RST;
         smp_lvl_reg  <= `CMF_SMP_RST;
         smp_prev_reg <= `CMF_SMP_RST;
      end
      else
      begin
         smp_s1_reg   <= comparator_sample_clock;
         smp_s2_reg   <= smp_s1_reg;
         smp_s3_reg   <= smp_s2_reg;
         smp_lvl_reg  <= smp_lvl_next;
         smp_prev_reg <= smp_lvl_reg;
      end
   end

   // One filter sample per rising edge of the settled sample clock.
   // A clock that idles high gives one tick after reset; the channels
   // ignore it because no comparison has been started yet.
   assign sample_tick = smp_lvl_reg & ~smp_prev_reg;

   ////////////////////////////////////////////////////////////////////
   // Raw comparator synchroniser

   // Settled comparator levels, one bit per channel
   always @*
   begin
      raw_lvl_next[0] = agree_level(raw_lvl_reg[0], raw_s2_reg[0],
                                    raw_s3_reg[0]);
      raw_lvl_next[1] = agree_level(raw_lvl_reg[1], raw_s2_reg[1],
                                    raw_s3_reg[1]);
   end

   // Three flip-flops on each asynchronous comparator output
   always @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         raw_s1_reg  <= `CMF_SYNC_RST;
         raw_s2_reg  <= `CMF_SYNC_RST;
         raw_s3_reg  <= `CMF_SYNC_RST;
         raw_lvl_reg <= `CMF_SYNC_RST;
      end
      else
      begin
         raw_s1_reg  <= comp_raw;
         raw_s2_reg  <= raw_s1_reg;
         raw_s3_reg  <= raw_s2_reg;
         raw_lvl_reg <= raw_lvl_next;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Front end controls

   // Hysteresis enable and level per channel
   always @*
   begin
      hysteresis_level_en_next[0]      = hysteresis_level_allowed(hysteresis_on[0],
                                          single_shot[0]);
      hysteresis_level_en_next[1]      = hysteresis_level_allowed(hysteresis_on[1],
                                          single_shot[1]);
      hysteresis_level_level_next[1:0] = hysteresis_level_level_for(hysteresis_on[0],
                                            hysteresis_level[1:0]);
      hysteresis_level_level_next[3:2] = hysteresis_level_level_for(hysteresis_on[1],
                                            hysteresis_level[3:2]);
   end

   // Registered controls; one cycle of latency is harmless next to
   // the settling time of the analog bias and hysteresis circuits
   always @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hysteresis_level_en_reg    <= `CMF_HYSTERESIS_LEVEL_EN_RST;
         hysteresis_level_level_reg <= `CMF_HYSTERESIS_LEVEL_LVL_RST;
         bias_sel_reg   <= `CMF_BIAS_RST;
      end
      else
      begin
         hysteresis_level_en_reg    <= hysteresis_level_en_next;
         hysteresis_level_level_reg <= hysteresis_level_level_next;
         bias_sel_reg   <= speed;
      end
   end

   // Drive the analog front end
   assign afe_hysteresis_level_en    = hysteresis_level_en_reg;
   assign afe_hysteresis_level_level = hysteresis_level_level_reg;
   assign afe_bias_sel   = bias_sel_reg;

   ////////////////////////////////////////////////////////////////////
   // Filter channels

   // Channel 0 uses the low bits of each shared field
   cmf_channel u_ch0
   (
      .sys_clk       (sys_clk),
      .sys_rst       (sys_rst),
      .sample_tick   (sample_tick),
      .raw_sync      (raw_lvl_reg[0]),
      .filter_length (filter_length[1:0]),
      .single_shot   (single_shot[0]),
      .start         (start[0]),
      .filt_out_reg  (filt_out[0]),
      .valid_reg     (filt_valid[0]),
      .done_reg      (comp_done[0])
   );

   // Channel 1 uses the high bits of each shared field
   cmf_channel u_ch1
   (
      .sys_clk       (sys_clk),
      .sys_rst       (sys_rst),
      .sample_tick   (sample_tick),
      .raw_sync      (raw_lvl_reg[1]),
      .filter_length (filter_length[3:2]),
      .single_shot   (single_shot[1]),
      .start         (start[1]),
      .filt_out_reg  (filt_out[1]),
      .valid_reg     (filt_valid[1]),
      .done_reg      (comp_done[1])
   );

endmodule

// ### hdl/cmf_regs.vh
// Constants for the comparator output majority filter
`ifndef CMF_REGS_VH
`define CMF_REGS_VH
// Number of comparator channels
`define CMF_NUM_CH        2
// Filter length encodings
`define CMF_FILTER_LENGTH_NONE     2'h0
`define CMF_FILTER_LENGTH_MAJ3     2'h1
`define CMF_FILTER_LENGTH_MAJ5     2'h2
// Sample counts per filter length
`define CMF_SAMPLES_NONE  3'h1
`define CMF_SAMPLES_MAJ3  3'h3
`define CMF_SAMPLES_MAJ5  3'h5
// Field widths
`define CMF_HYSTERESIS_LEVEL_W        2
`define CMF_SPEED_W       2
// Reset values
`define CMF_HIST_RST      5'h00
`define CMF_OUT_RST       1'h0
// Synchroniser and front end control reset values
`define CMF_SMP_RST       1'h0
`define CMF_SYNC_RST      2'h0
`define CMF_HYSTERESIS_LEVEL_EN_RST   2'h0
`define CMF_HYSTERESIS_LEVEL_LVL_RST  4'h0
`define CMF_BIAS_RST      4'h0
// Hysteresis level forwarded while hysteresis_on is clear
`define CMF_HYSTERESIS_LEVEL_LVL_OFF  2'h0
`endif

// ### hdl/cmf_channel.v
// One comparator channel: sampling, majority vote, validation timing
`timescale 1ns/1ps
`include "cmf_regs.vh"
module cmf_channel
(
   // Clock and reset
   input  wire       sys_clk,
   input  wire       sys_rst,
   // Sample strobe, one cycle per comparator_sample_clock period
   input  wire       sample_tick,
   // Raw comparator level, already synchronised
   input  wire       raw_sync,
   // Configuration
   input  wire [1:0] filter_length,
   input  wire       single_shot,
   input  wire       start,
   // Results
   output reg        filt_out_reg,
   output reg        valid_reg,
   output reg        done_reg
);

   reg  [4:0] hist_reg;   // Most recent samples, bit 0 newest
   reg  [2:0] cnt_reg;    // Samples taken since start
   reg        run_reg;    // Comparison in progress
   wire [4:0] hist_next;
   wire [2:0] need;
   wire [2:0] cnt_next;
   wire       vote;

   // Number of set bits in the low n samples
   function [2:0] ones;
      input [4:0] h;
      input [2:0] n;
      integer i;
      begin
         ones = 3'h0;
         for (i = 0; i < 5; i = i + 1)
            if (i < n)
               ones = ones + {2'h0, h[i]};
      end
   endfunction

   // Samples needed before the output is valid
   function [2:0] samples_for;
      input [1:0] fl;
      begin
         case (fl)
            `CMF_FILTER_LENGTH_MAJ3: samples_for = `CMF_SAMPLES_MAJ3;
            `CMF_FILTER_LENGTH_MAJ5: samples_for = `CMF_SAMPLES_MAJ5;
            default:        samples_for = `CMF_SAMPLES_NONE;
         endcase
      end
   endfunction

   assign need      = samples_for(filter_length);
   assign hist_next = {hist_reg[3:0], raw_sync};
   // Saturate at the current need, so a length changed mid-run still
   // validates instead of leaving the count stuck above it
   assign cnt_next  = (cnt_reg < need) ? cnt_reg + 3'h1 : need;
   // Majority: at least N/2+1 of the last N agree on high
   assign vote = (ones(hist_next, need) >= ((need >> 1) + 3'h1));

   ////////////////////////////////////////////////////////////////////
   // Sample history, counting and result
   always @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hist_reg     <= `CMF_HIST_RST;
         cnt_reg      <= 3'h0;
         run_reg      <= 1'b0;
         filt_out_reg <= `CMF_OUT_RST;
         valid_reg    <= 1'b0;
         done_reg     <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         if (start)
         begin
            // Old samples must not leak into a new comparison
            hist_reg  <= `CMF_HIST_RST;
            cnt_reg   <= 3'h0;
            run_reg   <= 1'b1;
            valid_reg <= 1'b0;
         end
         else if (run_reg && sample_tick)
         begin
            hist_reg <= hist_next;
            cnt_reg  <= cnt_next;
            // Validate only once N samples are in: N-1 extra sample periods
            if (cnt_next == need)
            begin
               filt_out_reg <= vote;
               valid_reg    <= 1'b1;
               if (single_shot)
               begin
                  // Single shot ends after the Nth sample
                  run_reg  <= 1'b0;
                  done_reg <= 1'b1;
               end
            end
         end
      end
   end

endmodule

// ### verif/cmf_top_checker.sv
// Port assertions for the comparator output majority filter
`timescale 1ns/1ps
module cmf_top_checker (
   input wire       sys_clk, sys_rst,
   input wire [1:0] comp_raw, single_shot, start, hysteresis_on,
   input wire [1:0] filt_out, filt_valid, comp_done, afe_hysteresis_level_en,
   input wire [3:0] filter_length, hysteresis_level, speed,
   input wire [3:0] afe_hysteresis_level_level, afe_bias_sel
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   AST_BIAS:
      assert property ($stable(speed)[*4] |-> afe_bias_sel == speed)
      else $error("bias select lags speed");
   AST_HYSTERESIS_LEVEL_EN:
      assert property ((hysteresis_on[0] && !single_shot[0])[*4]
         |-> afe_hysteresis_level_en[0]) else $error("hysteresis not enabled");
   AST_HYSTERESIS_LEVEL_SINGLE:
      assert property (single_shot[0][*4] |-> !afe_hysteresis_level_en[0])
      else $error("hysteresis in single shot");
   AST_HYSTERESIS_LEVEL_LEVEL:
      assert property ((hysteresis_on[0] && $stable(hysteresis_level))[*4]
         |-> afe_hysteresis_level_level[1:0] == hysteresis_level[1:0])
      else $error("hysteresis level lost");
   AST_NONE_PASS:
      assert property ((!filter_length[1:0] && !single_shot[0]
         && $stable(comp_raw[0]))[*8] ##0 filt_valid[0]
         |-> filt_out[0] == comp_raw[0]) else $error("bypass wrong");
   // Five samples at the sample rate cannot be gathered in ten cycles
   AST_EARLY_VALID:
      assert property ($rose(start[0]) && filter_length[1:0] == 2'h2
         |-> ##2 !filt_valid[0] [*8]) else $error("valid too early");
   AST_EARLY_DONE:
      assert property ($rose(start[0]) && filter_length[1:0] == 2'h2
         |-> ##2 !comp_done[0] [*8]) else $error("done too early");
   AST_DONE:
      assert property ($rose(start[0]) && single_shot[0]
         |-> ##[2:100] comp_done[0]) else $error("done missing");
   cover property ($rose(comp_done[0]));
   cover property ($rose(filt_valid[0]));
   cover property ($rose(afe_hysteresis_level_en[0]));
endmodule

// ### verif/cmf_afe_model.sv
// Comparator front end: divided sample clock and raw levels
`timescale 1ns/1ps
module cmf_afe_model (
   input  wire logic       sys_clk,
   input  wire logic [1:0] lvl,
   output logic            smp_clk = 1'b0,
   output logic [1:0]      raw = 2'h0
);
   logic [1:0] div_reg = 2'h0;
   // Four cycles per sample; raw moves mid high phase, clear of the edge
   always @(posedge sys_clk)
   begin
      div_reg <= div_reg + 2'h1;
      smp_clk <= div_reg[1];
      if (div_reg == 2'h3)
         raw <= lvl;
   end
endmodule

// ### verif/cmf_top_test.sv
// Self-checking bench for the comparator output majority filter
`timescale 1ns/1ps
module cmf_top_test;
   logic sys_clk = 0, sys_rst = 1, sclk;
   logic [1:0] lvl = 0, raw, st = 0, ss = 0, hon = 0, fo, fv, cd, he;
   logic [3:0] fl = 0, hl = 0, sp = 0, bs, hlo;
   int mismatches = 0, samples_checked = 0, cyc = 0, n;
   initial forever #25 sys_clk = ~sys_clk;
   cmf_afe_model afe (.sys_clk, .lvl, .smp_clk(sclk), .raw);
   cmf_top dut (.sys_clk, .sys_rst, .comparator_sample_clock(sclk),
      .comp_raw(raw), .filter_length(fl), .single_shot(ss), .start(st),
      .hysteresis_on(hon), .hysteresis_level(hl), .speed(sp),
      .filt_out(fo), .filt_valid(fv), .comp_done(cd), .afe_hysteresis_level_en(he),
      .afe_hysteresis_level_level(hlo), .afe_bias_sel(bs));
   task cmp(input logic [3:0] g, e);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask
   task w(input int k); repeat (k) @(posedge sys_clk); endtask
   // Start both channels; in single shot wait for done, bounded
   task go(input logic [1:0] s);
      ss <= s; st <= 2'h3; w(1); st <= 2'h0; n = 0;
      while (s && cd !== 2'h3 && n < 200) begin w(1); n++; end
   endtask
   task print_verdict;
      $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 3000) begin mismatches++; print_verdict; end
   end
   initial
   begin
      w(2); sys_rst <= 0; sp <= 4'h9; hon <= 2'h1; hl <= 4'h2; w(6);
      cmp(bs, 4'h9);
      cmp(he, 2'h1);
      cmp(hlo[1:0], 2'h2);
      ss <= 2'h1; w(6); cmp(he, 2'h0);
      for (int f = 0; f < 3; f++)
      begin
         fl <= {2{2'(f)}}; lvl <= 0; go(0); w(60); lvl <= 3; w(60);
         cmp({fv, fo}, 4'hf);
         lvl <= 0; // One stray sample must not flip a voting filter
         for (int i = 1; i < 17; i++)
         begin
            w(1); lvl <= (i < 4) ? 2'h0 : 2'h3;
            if (f) cmp(fo, 2'h3);
         end
         w(40); go(2'h3); cmp(n >= 8 * f && n < 8 * f + 12, 1);
      end
      print_verdict;
   end
endmodule
bind cmf_top cmf_top_checker chk (.*);
